// [ccm_far_model.sv]
// Far-side model: two analog comparators and eight port pins
`timescale 1ns/100ps
module ccm_far_model (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// Commanded analog outcome and outside pin levels
	input  wire logic [1:0] level_i,
	input  wire logic [7:0] ext_i,
	// From the block
	input  wire logic [1:0] cmp_enable_i,
	input  wire logic [7:0] pin_out_i,
	input  wire logic [7:0] pin_oe_i,
	// Towards the block
	output logic      [1:0] cmp_raw_o,
	output logic      [7:0] pin_in_o
);
	logic [1:0] idle_reg;

	// Unpowered comparator output is untrustworthy, so it wanders each cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_reg <= 2'b00;
		end else begin
			idle_reg <= ~idle_reg;
		end
	end

	// High when the non-inverting input is above the inverting one
	assign cmp_raw_o = (cmp_enable_i & level_i) | (~cmp_enable_i & idle_reg);
	// Driven pins read back the block's level, others the outside level
	assign pin_in_o  = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

// [ccm_mismatch_cell.sv]
// Read latch, phase-one sampling latch, mismatch detector and change flag
`timescale 1ns/100ps
module ccm_mismatch_cell (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Timing and software events
	input  wire logic q1_i,
	input  wire logic access_i,
	input  wire logic flag_wr_i,
	input  wire logic flag_val_i,
	// Comparator result
	input  wire logic result_i,
	// State
	output logic      flag_o,
	output logic      mismatch_o,
	output logic      read_latch_o
);
	logic sample_reg;
	logic read_latch_reg;
	logic flag_reg;
	logic mis_rise;

	// Both latches load on an access so a stale sample cannot fake a change
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_reg <= 1'b0;
		end else if (q1_i || access_i) begin
			sample_reg <= result_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_latch_reg <= 1'b0;
		end else if (access_i) begin
			read_latch_reg <= result_i;
		end
	end

	assign mismatch_o = sample_reg ^ read_latch_reg;
	assign mis_rise = q1_i && !access_i && (result_i ^ read_latch_reg);
	assign read_latch_o = read_latch_reg;
	assign flag_o = flag_reg;

	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_reg <= 1'b0;
		end else if (mis_rise || mismatch_o) begin
			flag_reg <= 1'b1;
		end else if (flag_wr_i) begin
			flag_reg <= flag_val_i;
		end
	end

	a_flag_on_change: assert property (@(posedge core_clk_i) disable iff (rst_i)
		mis_rise |=> flag_o && mismatch_o) else $error("flag not set on change");
	a_flag_held_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
		mismatch_o |=> flag_o) else $error("flag dropped during mismatch");
	a_access_ends_mismatch: assert property (@(posedge core_clk_i) disable iff (rst_i)
		access_i |=> !mismatch_o) else $error("access left mismatch");
	a_latch_holds_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!access_i |=> $stable(read_latch_o)) else $error("read latch moved");

endmodule

// [ccm_pkg.sv]
// Shared constants, types and decode functions for the comparator control block
package ccm_pkg;

	// Register byte addresses
	localparam logic [7:0] CCM_ADDR_CONFIG = 8'h00;
	localparam logic [7:0] CCM_ADDR_FLAG   = 8'h04;
	localparam logic [7:0] CCM_ADDR_ENABLE = 8'h08;
	localparam logic [7:0] CCM_ADDR_PORT   = 8'h0C;
	localparam logic [7:0] CCM_ADDR_DIR    = 8'h10;
	localparam logic [7:0] CCM_ADDR_PIN    = 8'h14;

	// Configuration register fields
	localparam int CCM_MODE_LSB   = 0;
	localparam int CCM_MODE_W     = 3;
	localparam int CCM_SWITCH_BIT = 3;
	localparam int CCM_INV_LSB    = 4;
	localparam int CCM_RESULT_LSB = 6;

	// Enable register fields
	localparam int CCM_IRQEN_LSB  = 0;
	localparam int CCM_PERIPH_BIT = 2;
	localparam int CCM_GLOBAL_BIT = 3;

	// Geometry
	localparam int CCM_NCMP       = 2;
	localparam int CCM_NPIN       = 8;
	localparam int CCM_PIN_STRIDE = 4;
	localparam int CCM_PIN_PLUS   = 0;
	localparam int CCM_PIN_MINUS_A = 1;
	localparam int CCM_PIN_MINUS_B = 2;
	localparam int CCM_PIN_OUT    = 3;

	// Reset values
	localparam logic [7:0] CCM_CONFIG_RST = 8'h00;
	localparam logic [3:0] CCM_ENABLE_RST = 4'h0;
	localparam logic [7:0] CCM_PORT_RST   = 8'h00;
	localparam logic [7:0] CCM_DIR_RST    = 8'hFF;
	localparam logic [7:0] CCM_ALL_IN_DUAL   = 8'h77;
	localparam logic [7:0] CCM_ALL_IN_SINGLE = 8'h07;

	// Mode codes
	localparam logic [2:0] CCM_MODE_OFF     = 3'h0;
	localparam logic [2:0] CCM_MODE_1       = 3'h1;
	localparam logic [2:0] CCM_MODE_2       = 3'h2;
	localparam logic [2:0] CCM_MODE_3       = 3'h3;
	localparam logic [2:0] CCM_MODE_5       = 3'h5;
	localparam logic [2:0] CCM_MODE_6       = 3'h6;
	localparam logic [2:0] CCM_MODE_DIGITAL = 3'h7;

	// Four system clock phases per instruction cycle
	typedef enum logic [1:0] {CCM_PH1, CCM_PH2, CCM_PH3, CCM_PH4} ccm_phase_t;

	function automatic logic ccm_cmp_on(input logic [2:0] mode);
		ccm_cmp_on = (mode != CCM_MODE_OFF) && (mode != CCM_MODE_DIGITAL);
	endfunction

	function automatic logic ccm_out_active(input logic [2:0] mode, input logic dual);
		if (dual) begin
			ccm_out_active = (mode == CCM_MODE_6);
		end else begin
			ccm_out_active = (mode == CCM_MODE_1) || (mode == CCM_MODE_3) ||
				(mode == CCM_MODE_5);
		end
	endfunction

	function automatic logic ccm_switch_active(input logic [2:0] mode, input int idx,
			input logic dual);
		if (dual) begin
			ccm_switch_active = ((mode == CCM_MODE_1) && (idx == 0)) || (mode == CCM_MODE_2);
		end else begin
			ccm_switch_active = (idx == 0) && ((mode == CCM_MODE_5) || (mode == CCM_MODE_6));
		end
	endfunction

	function automatic logic [7:0] ccm_analog_mask(input logic [2:0] mode, input logic dual);
		logic [7:0] m;
		m = '0;
		if (mode == CCM_MODE_OFF) begin
			m = dual ? CCM_ALL_IN_DUAL : CCM_ALL_IN_SINGLE;
		end else if (mode != CCM_MODE_DIGITAL) begin
			for (int c = 0; c < CCM_NCMP; c++) begin
				if ((c == 0) || dual) begin
					m[c * CCM_PIN_STRIDE + CCM_PIN_PLUS] = 1'b1;
					m[c * CCM_PIN_STRIDE + CCM_PIN_MINUS_A] = 1'b1;
					if (ccm_switch_active(mode, c, dual)) begin
						m[c * CCM_PIN_STRIDE + CCM_PIN_MINUS_B] = 1'b1;
					end
				end
			end
		end
		ccm_analog_mask = m;
	endfunction

endpackage

// [ccm_top.sv]
// Comparator mode control, output routing and change interrupt with Wishbone registers
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
import ccm_pkg::*;

// How it works
// - Three-bit mode picks one of eight pin setups
// - Analog pins lose input buffer; result overrides port
// - Analog pins read as zero on port reads
// - Result bits always readable in configuration register
// - Result drives pin only in listed modes
// - Result is comparison XOR invert bit
// - Inverting input switchable in listed modes only
// - Switch select picks pin; both stay analog
// - Read latch captures result on configuration read
// - Phase-one latch sample differing signals mismatch
// - Mismatch holds flag until read or return
// - Configuration write also reloads latch, clears mismatch
// - Flag cleared by writing zero, set by one
// - Request needs local, peripheral and global enables
// - Clear ineffective while mismatch persists
// - Change during read may leave flag unset
// - Reset returns configuration to off mode
module ccm_top #(
	parameter bit DUAL_PART = 1'b1
) (
	// Clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [7:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// Analog comparators
	input  wire logic [ccm_pkg::CCM_NCMP-1:0] cmp_raw_i,
	output logic      [ccm_pkg::CCM_NCMP-1:0] cmp_enable_o,
	output logic      [ccm_pkg::CCM_NCMP-1:0] cmp_switch_o,
	// Port pins
	input  wire logic [ccm_pkg::CCM_NPIN-1:0] pin_in_i,
	output logic      [ccm_pkg::CCM_NPIN-1:0] pin_out_o,
	output logic      [ccm_pkg::CCM_NPIN-1:0] pin_oe_o,
	output logic      [ccm_pkg::CCM_NPIN-1:0] pin_ibuf_en_o,
	// Interrupt request
	output logic                            irq_o
);
	import ccm_pkg::*;

	logic [7:0]          config_reg;
	logic [3:0]          enable_reg;
	logic [7:0]          port_reg;
	logic [7:0]          dir_reg;
	logic [7:0]          pin_meta_reg;
	logic [7:0]          pin_sync_reg;
	logic [CCM_NCMP-1:0] raw_meta_reg;
	logic [CCM_NCMP-1:0] raw_sync_reg;
	logic [CCM_NCMP-1:0] result;
	logic [CCM_NCMP-1:0] flag;
	logic [CCM_NCMP-1:0] mismatch;
	logic [CCM_NCMP-1:0] present;
	logic [7:0]          analog_mask;
	logic [7:0]          out_mask;
	logic [7:0]          pin_out_next;
	logic [7:0]          pin_oe_next;
	logic [31:0]         rd_data;
	logic [2:0]          mode;
	logic                out_on;
	logic                take;
	logic                wr;
	logic                cfg_access;
	logic                ack_reg;
	logic                q1;
	ccm_phase_t          phase_reg;
	ccm_phase_t          phase_next;

	assign mode = config_reg[CCM_MODE_LSB +: CCM_MODE_W];
	assign present = DUAL_PART ? 2'h3 : 2'h1;

	// Phase sequencer; the first phase is a one-cycle enable every fourth cycle
	always_comb begin
		case (phase_reg)
			CCM_PH1: phase_next = CCM_PH2;
			CCM_PH2: phase_next = CCM_PH3;
			CCM_PH3: phase_next = CCM_PH4;
			CCM_PH4: phase_next = CCM_PH1;
			default: phase_next = CCM_PH1;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= CCM_PH1;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign q1 = (phase_reg == CCM_PH1);

	// Comparator outputs and pins are asynchronous to the core clock
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			raw_meta_reg <= '0;
			raw_sync_reg <= '0;
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			raw_meta_reg <= cmp_raw_i;
			raw_sync_reg <= raw_meta_reg;
			pin_meta_reg <= pin_in_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// A disabled or absent comparator reads as low
	always_comb begin
		for (int c = 0; c < CCM_NCMP; c++) begin
			result[c] = present[c] && ccm_cmp_on(mode) &&
				(raw_sync_reg[c] ^ config_reg[CCM_INV_LSB + c]);
		end
	end

	// Wishbone: request taken on the first edge, ack one cycle later
	assign take = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr = take && wb_we_i && wb_sel_i[0];
	assign cfg_access = take && (wb_adr_i == CCM_ADDR_CONFIG);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take;
		end
	end

	assign wb_ack_o = ack_reg;

	always_comb begin
		rd_data = '0;
		case (wb_adr_i)
			CCM_ADDR_CONFIG: begin
				rd_data[5:0] = config_reg[5:0];
				rd_data[CCM_RESULT_LSB +: CCM_NCMP] = result;
			end
			CCM_ADDR_FLAG:   rd_data[CCM_NCMP-1:0] = flag;
			CCM_ADDR_ENABLE: rd_data[3:0] = enable_reg;
			CCM_ADDR_PORT:   rd_data[7:0] = port_reg;
			CCM_ADDR_DIR:    rd_data[7:0] = dir_reg;
			CCM_ADDR_PIN:    rd_data[7:0] = pin_sync_reg & ~analog_mask;
			default:         rd_data = '0;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (take) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
		end
	end

	// Result bits are read-only; the write keeps only mode, switch and invert
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_reg <= CCM_CONFIG_RST;
		end else if (wr && (wb_adr_i == CCM_ADDR_CONFIG)) begin
			config_reg <= {2'h0, wb_dat_i[5:0]};
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			enable_reg <= CCM_ENABLE_RST;
		end else if (wr && (wb_adr_i == CCM_ADDR_ENABLE)) begin
			enable_reg <= wb_dat_i[3:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_reg <= CCM_PORT_RST;
			dir_reg  <= CCM_DIR_RST;
		end else if (wr && (wb_adr_i == CCM_ADDR_PORT)) begin
			port_reg <= wb_dat_i[7:0];
		end else if (wr && (wb_adr_i == CCM_ADDR_DIR)) begin
			dir_reg <= wb_dat_i[7:0];
		end
	end

	// One mismatch circuit per comparator
	for (genvar g = 0; g < CCM_NCMP; g++) begin : g_cell
		ccm_mismatch_cell u_cell (
			.core_clk_i   (core_clk_i),
			.rst_i        (rst_i),
			.q1_i         (q1),
			.access_i     (cfg_access),
			.flag_wr_i    (wr && (wb_adr_i == CCM_ADDR_FLAG)),
			.flag_val_i   (wb_dat_i[g]),
			.result_i     (result[g]),
			.flag_o       (flag[g]),
			.mismatch_o   (mismatch[g]),
			.read_latch_o ()
		);
	end

	// Flags set regardless of enables; only the request is gated
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(flag & present & enable_reg[CCM_IRQEN_LSB +: CCM_NCMP]) &&
				enable_reg[CCM_PERIPH_BIT] && enable_reg[CCM_GLOBAL_BIT];
		end
	end

	// Pin routing
	assign analog_mask = ccm_analog_mask(mode, DUAL_PART);
	assign out_on = ccm_out_active(mode, DUAL_PART);

	always_comb begin
		out_mask = '0;
		for (int c = 0; c < CCM_NCMP; c++) begin
			out_mask[c * CCM_PIN_STRIDE + CCM_PIN_OUT] = out_on && present[c];
		end
	end

	always_comb begin
		pin_out_next = port_reg;
		for (int p = 0; p < CCM_NPIN; p++) begin
			if (out_mask[p]) begin
				pin_out_next[p] = result[p / CCM_PIN_STRIDE];
			end
		end
		pin_oe_next = ~dir_reg;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_out_o     <= '0;
			pin_oe_o      <= '0;
			pin_ibuf_en_o <= '0;
			cmp_enable_o  <= '0;
			cmp_switch_o  <= '0;
		end else begin
			pin_out_o     <= pin_out_next;
			pin_oe_o      <= pin_oe_next;
			pin_ibuf_en_o <= ~analog_mask;
			for (int c = 0; c < CCM_NCMP; c++) begin
				cmp_enable_o[c] <= present[c] && ccm_cmp_on(mode);
				cmp_switch_o[c] <= ccm_switch_active(mode, c, DUAL_PART) &&
					config_reg[CCM_SWITCH_BIT];
			end
		end
	end

	// A change sampled during a read is folded into the read latch, so no flag
	// results; software sees the new level in the read data instead.

	a_analog_reads_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		take && !wb_we_i && (wb_adr_i == CCM_ADDR_PIN) |=>
		(wb_dat_o[7:0] & $past(analog_mask)) == 8'h00)
		else $error("analog pin read non-zero");
	a_pin_out_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!out_on |=> pin_out_o == $past(port_reg))
		else $error("result driven in wrong mode");
	a_irq_enable_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!enable_reg[CCM_GLOBAL_BIT] || !enable_reg[CCM_PERIPH_BIT] |=> !irq_o)
		else $error("request without enables");
	a_result_invert: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ccm_cmp_on(mode) |-> result[0] == (raw_sync_reg[0] ^ config_reg[CCM_INV_LSB]))
		else $error("result polarity wrong");
	a_switch_mode_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!ccm_switch_active(mode, 0, DUAL_PART) |=> !cmp_switch_o[0])
		else $error("switch outside its modes");
	a_ack_one_cycle: assert property (@(posedge core_clk_i) disable iff (rst_i)
		take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not single cycle");
	a_switch_pins_analog: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ccm_switch_active(mode, 0, DUAL_PART) |-> analog_mask[CCM_PIN_MINUS_A] &&
		analog_mask[CCM_PIN_MINUS_B]) else $error("switch pin not analog");
	a_off_mode_disabled: assert property (@(posedge core_clk_i) disable iff (rst_i)
		mode == CCM_MODE_OFF |-> result == '0 ##1 cmp_enable_o == '0)
		else $error("comparator on in off mode");

endmodule

// [ccm_top_tb.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
module ccm_top_tb;
	import ccm_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic        cyc        = 1'b0;
	logic        stb        = 1'b0;
	logic        we         = 1'b0;
	logic [7:0]  adr        = 8'h00;
	logic [31:0] dat        = 32'h0000_0000;
	logic [31:0] q;
	logic [1:0]  lvl        = 2'b00;
	logic [7:0]  ext        = 8'h00;
	logic [1:0]  inv;
	logic [1:0]  r;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        irq_o;
	logic [1:0]  raw;
	logic [1:0]  cmp_en;
	logic [1:0]  cmp_sw;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [7:0]  ibuf;
	int          n_errors   = 0;
	int          n_compared = 0;
	int          seed       = 32'h7e00_57a2;

	always #50 core_clk_i = ~core_clk_i;

	ccm_top #(.DUAL_PART(1'b1)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_raw_i(raw),
		.cmp_enable_o(cmp_en), .cmp_switch_o(cmp_sw), .pin_in_i(pin_in),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_ibuf_en_o(ibuf), .irq_o(irq_o));

	ccm_far_model i_far (.core_clk_i(core_clk_i), .rst_i(rst_i), .level_i(lvl),
		.ext_i(ext), .cmp_enable_i(cmp_en), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
		.cmp_raw_o(raw), .pin_in_o(pin_in));

	// Analog pins per mode, dual part
	function automatic logic [7:0] amask(input logic [2:0] m);
		amask = (m == 3'h0 || m == 3'h2) ? 8'h77 : (m == 3'h7) ? 8'h00 :
			(m == 3'h1) ? 8'h37 : 8'h33;
	endfunction

	task results;
		if (n_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Classic single cycle; data taken at the edge that samples ack high
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		do begin
			@(posedge core_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			results;
		end
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task cyc_wait(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	initial begin
		#4_000_000;
		n_errors++;
		results;
	end

	initial begin
		cyc_wait(2);
		rst_i <= 1'b0;
		wb(1'b0, CCM_ADDR_CONFIG, 8'h00);
		chk("config reset", q, 0);
		chk("enable reset", cmp_en, 0);
		wb(1'b0, CCM_ADDR_DIR, 8'h00);
		chk("dir reset", q, 32'h0000_00FF);
		wb(1'b0, 8'h20, 8'h00);
		chk("unmapped", q, 0);
		for (int m = 0; m < 8; m++) begin
			for (int s = 0; s < 2; s++) begin
				wb(1'b1, CCM_ADDR_CONFIG, {4'h0, s[0], m[2:0]});
				cyc_wait(3);
				chk("ibuf", ibuf, {~amask(m[2:0])});
				chk("cmp on", cmp_en, (m == 0 || m == 7) ? 2'b00 : 2'b11);
				chk("switch", cmp_sw, s ? ((m == 2) ? 2'b11 : (m == 1) ? 2'b01 : 2'b00) : 2'b00);
			end
		end
		// Output pins 3 and 7 driven, analog pins left as inputs
		wb(1'b1, CCM_ADDR_DIR, 8'h77);
		for (int i = 0; i < 6; i++) begin
			inv = $random(seed);
			lvl <= $random(seed);
			ext <= $random(seed);
			wb(1'b1, CCM_ADDR_CONFIG, {2'b00, inv, 1'b0, CCM_MODE_6});
			cyc_wait(8);
			r = lvl ^ inv;
			wb(1'b0, CCM_ADDR_CONFIG, 8'h00);
			chk("result", q[7:6], r);
			chk("out pin", {pin_out[7], pin_out[3]}, r);
			wb(1'b0, CCM_ADDR_PIN, 8'h00);
			chk("pin read", q, ((ext & 8'h44) | {r[1], 3'h0, r[0], 3'h0}));
		end
		chk("pin oe", pin_oe, 8'h88);
		lvl <= 2'b00;
		wb(1'b1, CCM_ADDR_CONFIG, {5'h00, CCM_MODE_2});
		// Bias settling, then clear mismatch and flags
		cyc_wait(12);
		wb(1'b0, CCM_ADDR_CONFIG, 8'h00);
		wb(1'b1, CCM_ADDR_FLAG, 8'h00);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag quiet", q, 0);
		lvl <= 2'b01;
		cyc_wait(10);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag set", q, 1);
		wb(1'b1, CCM_ADDR_FLAG, 8'h00);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag held", q, 1);
		wb(1'b1, CCM_ADDR_CONFIG, {5'h00, CCM_MODE_2});
		wb(1'b1, CCM_ADDR_FLAG, 8'h00);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag clr", q, 0);
		lvl <= 2'b11;
		cyc_wait(10);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag c1", q, 2);
		wb(1'b0, CCM_ADDR_CONFIG, 8'h00);
		wb(1'b1, CCM_ADDR_FLAG, 8'h00);
		wb(1'b0, CCM_ADDR_FLAG, 8'h00);
		chk("flag c1 clr", q, 0);
		wb(1'b1, CCM_ADDR_CONFIG, {5'h00, CCM_MODE_DIGITAL});
		// Turning the comparators off is itself a change; end that mismatch first
		wb(1'b0, CCM_ADDR_CONFIG, 8'h00);
		wb(1'b1, CCM_ADDR_FLAG, 8'h01);
		for (int e = 0; e < 8; e++) begin
			wb(1'b1, CCM_ADDR_ENABLE, {4'h0, e[2], e[1], 1'b0, e[0]});
			cyc_wait(3);
			chk("irq", irq_o, (e == 7));
			wb(1'b0, CCM_ADDR_FLAG, 8'h00);
			chk("flag kept", q, 1);
		end
		results;
	end
endmodule
